//--- rtl/isd_space_decoder.sv
// Purpose: Decodes the special register space with endpoint and port banks.
// Assumes: Core issues single-byte accesses synchronous to clk_sys.
// Notes: Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
module isd_space_decoder
  import isd_pkg::*;
#(
  parameter int N_PORT = 6,
  parameter int HOLD = RESET_HOLD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic cpu_idle,
  input wire logic cpu_powerdown,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  output logic sfr_hit,
  output logic [7:0] endpoint_select,
  output logic [7:0] hub_port_select,
  output logic wake_to_run,
  output logic core_in_reset
);

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  initial begin
    if (N_PORT < 1 || N_PORT > (1 << PORT_IDX_W)) begin
      $error("isd_space_decoder: N_PORT out of range");
    end
  end

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [N_PLAIN-1:0][7:0] plain;
    logic [N_EP_BANK-1:0][N_EP_REG-1:0][7:0] ep;
    logic [N_PORT-1:0][N_PORT_REG-1:0][7:0] port;
    logic [7:0] rdata;
    logic rvalid;
    logic hit;
  } isd_state_t;

  // Builds the full reset image, including the per-bank control byte.
  function automatic isd_state_t isd_reset_image();
    isd_state_t s;
    s = '0;
    for (int i = 0; i < N_PLAIN; i++) begin
      s.plain[i] = PLAIN_RST[i];
    end
    for (int b = 0; b < N_EP_BANK; b++) begin
      for (int r = 0; r < N_EP_REG; r++) begin
        s.ep[b][r] = EP_RST[r];
      end
      s.ep[b][0] = EP_CTRL_RST[b];
    end
    for (int p = 0; p < N_PORT; p++) begin
      for (int r = 0; r < N_PORT_REG; r++) begin
        s.port[p][r] = PORT_RST[r];
      end
    end
    return s;
  endfunction : isd_reset_image

  localparam isd_state_t ST_RESET = isd_reset_image();

  isd_state_t st;
  isd_state_t next_st;
  logic core_rst;

  // ---------------------------------------------------------------------
  // Reset qualification
  // ---------------------------------------------------------------------
  // Short glitches on the pin are ignored; only a held pulse resets the core.
  isd_reset_qual #(
    .HOLD(HOLD)
  ) u_qual (
    .clk_sys(clk_sys),
    .rst(rst),
    .core_rst(core_rst)
  );

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  logic [N_PLAIN-1:0] plain_hit;
  logic [N_EP_REG-1:0] ep_hit;
  logic [N_PORT_REG-1:0] port_hit;
  logic [7:0] ep_sel;
  logic [7:0] port_sel;
  logic ep_bank_ok;
  logic [2:0] ep_bank;
  logic port_ok;
  logic [PORT_IDX_W-1:0] port_idx;

  // One comparator per register location.
  genvar gi;
  generate
    for (gi = 0; gi < N_PLAIN; gi++) begin : g_plain
      assign plain_hit[gi] = (sfr_addr == PLAIN_ADDR[gi]);
    end
    for (gi = 0; gi < N_EP_REG; gi++) begin : g_ep
      assign ep_hit[gi] = (sfr_addr == EP_ADDR[gi]);
    end
    for (gi = 0; gi < N_PORT_REG; gi++) begin : g_port
      assign port_hit[gi] = (sfr_addr == PORT_ADDR[gi]);
    end
  endgenerate

  // The select registers are themselves plain storage, so a new value
  // written in one cycle steers the access of the next cycle.
  always_comb begin
    ep_sel = 8'h00;
    port_sel = 8'h00;
    for (int i = 0; i < N_PLAIN; i++) begin
      if (PLAIN_ADDR[i] == ADDR_ENDPOINT_SELECT) begin
        ep_sel = st.plain[i];
      end
      if (PLAIN_ADDR[i] == ADDR_PORT_SELECT) begin
        port_sel = st.plain[i];
      end
    end
  end

  // Endpoint index: top bit picks hub or function, low bits the endpoint.
  always_comb begin
    ep_bank = 3'h0;
    ep_bank_ok = 1'b0;
    if (ep_sel[6:2] == 5'h00) begin
      if (ep_sel[EP_HUB_BIT]) begin
        ep_bank_ok = (ep_sel[1:0] < 2'h2);
        ep_bank = ep_sel[0] ? 3'(EP_BANK_HUB1) : 3'(EP_BANK_HUB0);
      end else begin
        ep_bank_ok = (int'(ep_sel[1:0]) < EP_FUNC_COUNT);
        ep_bank = {1'b0, ep_sel[1:0]};
      end
    end
  end

  // Port index: low bits of the port select register.
  always_comb begin
    port_idx = port_sel[PORT_IDX_W-1:0];
    port_ok = (port_sel[7:PORT_IDX_W] == '0) && (int'(port_idx) < N_PORT);
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // Each access is one byte; the bus has no wider path.
  // A location that decodes to nothing neither stores nor reports a hit.
  always_comb begin
    logic ep_valid;
    logic any_hit;
    logic [7:0] rd;
    ep_valid = 1'b0;
    any_hit = 1'b0;
    rd = UNIMPL_READ;
    next_st = st;
    next_st.rvalid = sfr_rd;
    // Unbanked registers.
    for (int i = 0; i < N_PLAIN; i++) begin
      if (plain_hit[i]) begin
        any_hit = 1'b1;
        rd = st.plain[i];
        if (sfr_wr) begin
          next_st.plain[i] = sfr_wdata;
        end
      end
    end
    // Endpoint banks; hub endpoint 1 holds only transmit data.
    for (int r = 0; r < N_EP_REG; r++) begin
      ep_valid = ep_bank_ok && ((int'(ep_bank) != EP_BANK_HUB1) || (r == EP_TX_FIFO_DATA_IDX));
      if (ep_hit[r] && ep_valid) begin
        any_hit = 1'b1;
        rd = st.ep[ep_bank][r];
        if (sfr_wr) begin
          next_st.ep[ep_bank][r] = sfr_wdata;
        end
      end
    end
    // Port banks.
    for (int r = 0; r < N_PORT_REG; r++) begin
      if (port_hit[r] && port_ok) begin
        any_hit = 1'b1;
        rd = st.port[port_idx][r];
        if (sfr_wr) begin
          next_st.port[port_idx][r] = sfr_wdata;
        end
      end
    end
    // Unmatched writes fall through every loop and leave storage alone.
    if (!any_hit) begin
      next_st.hit = 1'b0;
    end else begin
      next_st.hit = 1'b1;
    end
    if (sfr_rd) begin
      next_st.rdata = rd;
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // The qualified reset loads the whole mapped image at once.
  always_ff @(posedge clk_sys or posedge core_rst) begin
    if (core_rst) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Reset indication; the pin raises it at once, the qualifier keeps it up.
  logic core_rst_q;

  // Registers the reset indication straight to its output.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= core_rst;
    end
  end

  // Wake request is kept outside the core reset so it can leave low power.
  // Idle or powerdown plus the pin raises the run request.
  logic wake_hold;
  always_ff @(posedge clk_sys) begin
    wake_hold <= rst && (cpu_idle || cpu_powerdown);
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign sfr_rdata = st.rdata;
  assign sfr_rvalid = st.rvalid;
  assign sfr_hit = st.hit;
  assign endpoint_select = ep_sel;
  assign hub_port_select = port_sel;
  assign wake_to_run = wake_hold;
  assign core_in_reset = core_rst_q;

endmodule : isd_space_decoder

//--- rtl/isd_pkg.sv
// Purpose: Constants for the byte-wide special register space decoder.
// Assumes: One 8-bit register bus from the processor core, one clock.
// Notes: Indeterminate reset bits are cleared to zero.
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package isd_pkg;

  // Reset qualification time, in clock periods, and its cycle count.
  localparam int RESET_HOLD_PERIODS = 64;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_PERIODS;

  // ---------------------------------------------------------------------
  // Unbanked registers
  // ---------------------------------------------------------------------
  localparam int N_PLAIN = 30;
  localparam logic [7:0] ADDR_PORT_SELECT = 8'hD4;
  localparam logic [7:0] ADDR_ENDPOINT_SELECT = 8'hF1;
  localparam logic [0:N_PLAIN-1][7:0] PLAIN_ADDR = {
    8'hA0, 8'hA1, 8'hA2, 8'hA8, 8'hA9, 8'hAE, 8'hB0, 8'hB1, 8'hB2, 8'hB3,
    8'hB7, 8'hB8, 8'hB9, 8'hC0, 8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD,
    8'hD0, 8'hD2, 8'hD3, 8'hD4, 8'hDF, 8'hE0, 8'hE8, 8'hF0, 8'hF1, 8'hF8};
  localparam logic [0:N_PLAIN-1][7:0] PLAIN_RST = {
    8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};

  // ---------------------------------------------------------------------
  // Endpoint-banked registers
  // ---------------------------------------------------------------------
  localparam int N_EP_REG = 11;
  localparam int N_EP_BANK = 5;
  localparam int EP_TX_FIFO_DATA_IDX = 7;
  localparam int EP_BANK_HUB0 = 3;
  localparam int EP_BANK_HUB1 = 4;
  localparam int EP_FUNC_COUNT = 3;
  localparam int EP_HUB_BIT = 7;
  localparam logic [0:N_EP_REG-1][7:0] EP_ADDR = {
    8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6};
  // Common pattern; the control byte varies per bank.
  localparam logic [0:N_EP_REG-1][7:0] EP_RST = {
    8'h00, 8'h00, 8'h00, 8'h04, 8'h08, 8'h00, 8'h00, 8'h00, 8'h04, 8'h08, 8'h00};
  localparam logic [0:N_EP_BANK-1][7:0] EP_CTRL_RST = {
    8'h35, 8'h10, 8'h10, 8'h35, 8'h00};

  // ---------------------------------------------------------------------
  // Port-banked registers
  // ---------------------------------------------------------------------
  localparam int N_PORT_REG = 3;
  localparam int PORT_IDX_W = 3;
  localparam logic [0:N_PORT_REG-1][7:0] PORT_ADDR = {8'hCF, 8'hD5, 8'hD7};
  localparam logic [0:N_PORT_REG-1][7:0] PORT_RST = {8'h00, 8'h00, 8'h80};

  // Value read back from an unimplemented location.
  localparam logic [7:0] UNIMPL_READ = 8'h00;

endpackage : isd_pkg

//--- rtl/isd_reset_qual.sv
// Purpose: Qualifies the reset pin so only a long enough pulse resets the core.
// Assumes: Reset pin is synchronous to clk_sys.
// Notes: The history shift register needs no reset of its own.
`timescale 1ns/1ps
module isd_reset_qual
  import isd_pkg::*;
#(
  parameter int HOLD = RESET_HOLD_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic core_rst
);

  initial begin
    if (HOLD < 2) begin
      $error("isd_reset_qual: HOLD must be at least 2");
    end
  end

  typedef struct packed {
    logic [HOLD-1:0] hist;
    logic core_rst;
  } isd_qual_t;

  isd_qual_t st;
  isd_qual_t next_st;

  // ---------------------------------------------------------------------
  // History of the pin
  // ---------------------------------------------------------------------
  // A low sample anywhere in the window keeps the core out of reset, so the
  // result is defined once the pin has been low for a single cycle.
  always_comb begin
    next_st = st;
    next_st.hist = {st.hist[HOLD-2:0], rst};
    if (!rst) begin
      next_st.core_rst = 1'b0;
    end else if (&st.hist) begin
      next_st.core_rst = 1'b1;
    end
  end

  // Registers the qualifier state.
  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign core_rst = st.core_rst;

endmodule : isd_reset_qual

//--- verification/isd_space_decoder_asserts.sv
// Purpose: Port-level checks for the special register space decoder.
// Assumes: One clock clk_sys and the reset pin rst.
// Notes: Bound to the design from the testbench top file.
`timescale 1ns/1ps
module isd_space_decoder_asserts #(
  parameter int N_PORT = 6,
  parameter int HOLD = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rvalid,
  input wire logic sfr_hit,
  input wire logic [7:0] endpoint_select,
  input wire logic [7:0] hub_port_select,
  input wire logic wake_to_run,
  input wire logic core_in_reset
);
  logic [7:0] hi_cnt = 8'h00;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Counts consecutive high samples of the reset pin, saturating.
  always_ff @(posedge clk_sys) begin
    hi_cnt <= rst ? hi_cnt + {7'h00, hi_cnt != 8'hFF} : 8'h00;
  end
  property p_rv_on;
    sfr_rd |=> sfr_rvalid;
  endproperty
  a_rv_on: assert property (p_rv_on) else $error("read not answered");
  property p_rv_off;
    !sfr_rd |=> !sfr_rvalid;
  endproperty
  a_rv_off: assert property (p_rv_off) else $error("stray read valid");
  property p_ep_sel;
    sfr_wr && sfr_addr == 8'hF1 |=> endpoint_select == $past(sfr_wdata);
  endproperty
  a_ep_sel: assert property (p_ep_sel) else $error("endpoint select not loaded");
  property p_port_sel;
    sfr_wr && sfr_addr == 8'hD4 |=> hub_port_select[2:0] == $past(sfr_wdata[2:0]);
  endproperty
  a_port_sel: assert property (p_port_sel) else $error("port select not loaded");
  property p_sel_hold;
    !(sfr_wr && sfr_addr == 8'hF1) |=> $stable(endpoint_select);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("endpoint select moved");
  property p_low_miss;
    (sfr_rd || sfr_wr) && !sfr_addr[7] |=> !sfr_hit;
  endproperty
  a_low_miss: assert property (p_low_miss) else $error("hit outside space");
  property p_hub1;
    sfr_rd && endpoint_select == 8'h81 && sfr_addr == 8'hE1 |=> !sfr_hit;
  endproperty
  a_hub1: assert property (p_hub1) else $error("hub ep1 control hit");
  property p_port_rng;
    sfr_rd && sfr_addr == 8'hCF && int'(hub_port_select) >= N_PORT |=> !sfr_hit;
  endproperty
  a_port_rng: assert property (p_port_rng) else $error("port bank out of range");
  property p_wake_off;
    !rst |=> !wake_to_run;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake without reset");
  property p_qual;
    disable iff (1'b0) int'(hi_cnt) >= HOLD + 2 |-> core_in_reset;
  endproperty
  a_qual: assert property (p_qual) else $error("long reset not taken");
  property p_rel;
    disable iff (1'b0) !rst ##1 !rst |=> rst || !core_in_reset;
  endproperty
  a_rel: assert property (p_rel) else $error("core reset stuck");
  c_hub1_tx: cover property (sfr_rd && endpoint_select == 8'h81 && sfr_addr == 8'hF3 ##1 sfr_hit);
  c_wake: cover property (@(posedge clk_sys) disable iff (1'b0) wake_to_run);
  c_core: cover property (@(posedge clk_sys) disable iff (1'b0) core_in_reset);
endmodule : isd_space_decoder_asserts

//--- verification/testbench.sv
// Purpose: Self-checking bench for the special register space decoder.
// Assumes: Reset qualifier shortened to HOLD cycles.
// Notes: Each scenario task judges its own results.
`timescale 1ns/1ps
module testbench;
  import isd_pkg::*;
  localparam int HOLD = 4;
  localparam int NP = 6;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic cpu_idle = 1'b0;
  logic cpu_powerdown = 1'b0;
  logic [7:0] sfr_rdata, endpoint_select, hub_port_select;
  logic sfr_rvalid, sfr_hit, wake_to_run, core_in_reset;
  int bad_count = 0;
  int tests_run = 0;
  logic [0:3][7:0] codes = {8'h00, 8'h01, 8'h02, 8'h80};
  isd_space_decoder #(.N_PORT(NP), .HOLD(HOLD)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .cpu_idle(cpu_idle), .cpu_powerdown(cpu_powerdown), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .sfr_hit(sfr_hit), .endpoint_select(endpoint_select),
    .hub_port_select(hub_port_select), .wake_to_run(wake_to_run),
    .core_in_reset(core_in_reset));
  // Free-running system clock.
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    #1;
  endtask : wr
  // Reads one byte; the hit flag is judged always, the byte only on a hit.
  task automatic rdx(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1;
    chk({7'h00, sfr_rvalid}, 8'h01);
    chk({7'h00, sfr_hit}, {7'h00, hit});
    if (hit) chk(sfr_rdata, exp);
  endtask : rdx
  task automatic pulse(input int n);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse
  task automatic t_reset_vals();
    rdx(8'hA0, 8'hFF, 1'b1);
    rdx(8'hD3, 8'h08, 1'b1);
    rdx(8'hF1, 8'h80, 1'b1);
    rdx(8'hA8, 8'h00, 1'b1);
    rdx(8'hD7, 8'h80, 1'b1);
    chk(endpoint_select, 8'h80);
  endtask : t_reset_vals
  task automatic t_unimpl();
    wr(8'hA3, 8'h5A);
    rdx(8'hA3, 8'h00, 1'b0);
    rdx(8'hA0, 8'hFF, 1'b1);
  endtask : t_unimpl
  task automatic t_ep_banks();
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ENDPOINT_SELECT, codes[i]);
      chk(endpoint_select, codes[i]);
      rdx(8'hE1, EP_CTRL_RST[i], 1'b1);
      wr(8'hE2, 8'h40 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ENDPOINT_SELECT, codes[i]);
      rdx(8'hE2, 8'h40 + 8'(i), 1'b1);
    end
  endtask : t_ep_banks
  task automatic t_hub1();
    wr(ADDR_ENDPOINT_SELECT, 8'h81);
    wr(8'hF3, 8'hC3);
    rdx(8'hF3, 8'hC3, 1'b1);
    wr(8'hE2, 8'h77);
    rdx(8'hE1, 8'h00, 1'b0);
    wr(ADDR_ENDPOINT_SELECT, 8'h80);
    rdx(8'hE2, 8'h43, 1'b1);
  endtask : t_hub1
  task automatic t_ports();
    for (int p = 0; p < NP; p++) begin
      wr(ADDR_PORT_SELECT, 8'(p));
      wr(8'hCF, 8'h10 + 8'(p));
    end
    for (int p = NP - 1; p >= 0; p--) begin
      wr(ADDR_PORT_SELECT, 8'(p));
      chk(hub_port_select, 8'(p));
      rdx(8'hCF, 8'h10 + 8'(p), 1'b1);
    end
    wr(ADDR_PORT_SELECT, 8'(NP));
    rdx(8'hCF, 8'h00, 1'b0);
  endtask : t_ports
  task automatic t_resets();
    wr(8'hA8, 8'h55);
    @(posedge clk_sys);
    cpu_idle <= 1'b1;
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({7'h00, wake_to_run}, 8'h01);
    @(posedge clk_sys);
    rst <= 1'b0;
    cpu_idle <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({7'h00, core_in_reset}, 8'h00);
    rdx(8'hA8, 8'h55, 1'b1);
    pulse(HOLD + 2);
    rdx(8'hA8, 8'h00, 1'b1);
    chk(hub_port_select, 8'h00);
    rdx(8'hE1, EP_CTRL_RST[EP_BANK_HUB0], 1'b1);
    @(posedge clk_sys);
    cpu_powerdown <= 1'b1;
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({7'h00, wake_to_run}, 8'h01);
    @(posedge clk_sys);
    rst <= 1'b0;
    cpu_powerdown <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h00, wake_to_run}, 8'h00);
    chk({7'h00, core_in_reset}, 8'h00);
  endtask : t_resets
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // Main sequence: reset held from the start until qualified, then every scenario.
  initial begin
    repeat (HOLD + 4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset_vals();
    t_unimpl();
    t_ep_banks();
    t_hub1();
    t_ports();
    t_resets();
    summarize();
  end
  // Watchdog well beyond the expected run of some 160 cycles.
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule : testbench
bind isd_space_decoder isd_space_decoder_asserts #(.N_PORT(N_PORT), .HOLD(HOLD)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rvalid(sfr_rvalid), .sfr_hit(sfr_hit),
  .endpoint_select(endpoint_select), .hub_port_select(hub_port_select),
  .wake_to_run(wake_to_run), .core_in_reset(core_in_reset));
